// ---- src/dcm_pkg.sv ----
// Package with offsets, field positions, reset values and timing constants of the card multiplexer registers.
package dcm_pkg;
   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Register offsets, as seen by the two-wire host in the pointer byte.
   localparam logic [7:0] OFS_IDENT = 8'h00;
   localparam logic [7:0] OFS_DRV_VER = 8'h01;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SLOT_CTRL = 8'h08;
   localparam logic [7:0] OFS_BAT_DEB = 8'h0A;
   localparam logic [7:0] OFS_SW_DEB = 8'h0B;
   localparam logic [7:0] OFS_RSVD = 8'h0C;
   localparam logic [7:0] OFS_CLK_CTRL = 8'h0D;
   localparam logic [7:0] OFS_DEV_CTRL = 8'h0E;
   localparam logic [7:0] OFS_TEST_FIRST = 8'h10;
   localparam logic [7:0] OFS_TEST_LAST = 8'h14;
   localparam logic [7:0] OFS_PULLUP = 8'h15;
   localparam int TEST_REGS = 5;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Values after reset and fixed read values.
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DEB_COUNT = 8'h04;
   localparam logic [7:0] DRV_VERSION = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Status register field positions.
   localparam int ST_SW_LEVEL = 0;
   localparam int ST_SW_FLAG = 1;
   localparam int ST_BAT_GONE = 2;
   localparam int ST_BAT_FLAG = 3;
   localparam int ST_SLOT1_LSB = 4;
   localparam int ST_SLOT2_LSB = 6;

   // Slot control fields, relative to each slot nibble.
   localparam int SC_NIBBLE = 4;
   localparam int SC_REG_EN = 0;
   localparam int SC_VSEL = 1;
   localparam int SC_STATE_LSB = 2;

   // Slot status codes.
   localparam logic [1:0] SLOT_POWERED_DOWN = 2'h0;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Debounce time base: one tick per period of the low-speed time reference.
   localparam int CLK_PERIOD_NS = 20;
   localparam int DEB_TICK_NS = 31250;
   localparam int DEB_TICK_CYC = DEB_TICK_NS / CLK_PERIOD_NS;

   // Default seven-bit two-wire address of the device; the value is arbitrary.
   localparam logic [6:0] I2C_DEV_ADDR_DEF = 7'h35;

   // Arbitrary identity nibbles used as defaults.
   localparam logic [3:0] MAKER_NIBBLE_DEF = 4'hA;
   localparam logic [3:0] DEVICE_NIBBLE_DEF = 4'h5;
endpackage : dcm_pkg

// ---- src/dcm_reg_if.sv ----
// Interface carrying register strobes between the two-wire slave and the register map.
`timescale 1ns/1ps
interface dcm_reg_if;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport master (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
   modport target (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : dcm_reg_if

// ---- src/dcm_i2c_slave.sv ----
// Two-wire serial slave that turns bus transfers into register reads and writes with auto-increment.
`timescale 1ns/1ps
module dcm_i2c_slave #(
   parameter logic [6:0] DEV_ADDR = dcm_pkg::I2C_DEV_ADDR_DEF
) (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Bus pins.
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_drv_b_o,
   // Register side.
   dcm_reg_if.master bus
);
   import dcm_pkg::*;

   typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WR, WR_ACK, RD, RD_ACK} dcm_i2c_st_t;

   dcm_i2c_st_t state_r, state_nxt;
   logic [2:0] scl_s_r;
   logic [2:0] sda_s_r;
   logic [7:0] shift_r, shift_nxt;
   logic [3:0] bits_r, bits_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic ptr_set_r, ptr_set_nxt;
   logic read_r, read_nxt;
   logic drv_r, drv_nxt;
   logic load_c;

   // Pins pass two flops; edges compare the second stage with its delayed copy.
   always_ff @(posedge clk_sys_i) begin
      scl_s_r <= rst_b_i ? {scl_s_r[1:0], scl_i} : 3'h7;
      sda_s_r <= rst_b_i ? {sda_s_r[1:0], sda_i} : 3'h7;
   end

   wire scl_rise = scl_s_r[1] & ~scl_s_r[2];
   wire scl_fall = ~scl_s_r[1] & scl_s_r[2];
   wire bus_start = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
   wire bus_stop = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];

   // Next-state logic of the byte engine.
   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      bits_nxt = bits_r;
      ptr_nxt = ptr_r;
      ptr_set_nxt = ptr_set_r;
      read_nxt = read_r;
      drv_nxt = drv_r;
      bus.wr_stb = 1'b0;
      load_c = 1'b0;
      if (bus_stop) begin
         state_nxt = IDLE;
         drv_nxt = 1'b0;
      end else if (bus_start) begin
         state_nxt = ADDR;
         bits_nxt = 4'h0;
         ptr_set_nxt = 1'b0;
         drv_nxt = 1'b0;
      end else begin
         case (state_r)
            ADDR, WR: begin
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], sda_s_r[1]};
                  bits_nxt = bits_r + 4'h1;
               end else if (scl_fall && bits_r == 4'h8) begin
                  bits_nxt = 4'h0;
                  if (state_r == ADDR) begin
                     state_nxt = (shift_r[7:1] == DEV_ADDR) ? ADDR_ACK : IDLE;
                     drv_nxt = (shift_r[7:1] == DEV_ADDR);
                     read_nxt = shift_r[0];
                  end else begin
                     state_nxt = WR_ACK;
                     drv_nxt = 1'b1;
                     ptr_set_nxt = 1'b1;
                     bus.wr_stb = ptr_set_r;
                     ptr_nxt = ptr_set_r ? ptr_r + 8'h01 : shift_r;
                  end
               end
            end
            ADDR_ACK, WR_ACK: begin
               if (scl_fall) begin
                  load_c = (state_r == ADDR_ACK) && read_r;
                  state_nxt = WR;
                  drv_nxt = 1'b0;
               end
            end
            RD: begin
               if (scl_fall) begin
                  bits_nxt = bits_r + 4'h1;
                  shift_nxt = {shift_r[6:0], 1'b0};
                  drv_nxt = (bits_r != 4'h7) && !shift_r[6];
                  state_nxt = (bits_r == 4'h7) ? RD_ACK : RD;
               end
            end
            RD_ACK: begin
               if (scl_rise && sda_s_r[1]) begin
                  state_nxt = IDLE;
               end else if (scl_fall) begin
                  load_c = 1'b1;
               end
            end
            default: state_nxt = IDLE;
         endcase
         // Fetch the next byte at the pointer and put its first bit on the line.
         if (load_c) begin
            shift_nxt = bus.rdata;
            ptr_nxt = ptr_r + 8'h01;
            bits_nxt = 4'h0;
            drv_nxt = !bus.rdata[7];
            state_nxt = RD;
         end
      end
   end

   assign bus.rd_stb = load_c;
   assign bus.addr = ptr_r;
   assign bus.wdata = shift_r;
   assign sda_drv_b_o = !drv_r;

   // State registers.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         state_r <= IDLE;
         shift_r <= 8'h00;
         bits_r <= 4'h0;
         ptr_r <= 8'h00;
         ptr_set_r <= 1'b0;
         read_r <= 1'b0;
         drv_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         bits_r <= bits_nxt;
         ptr_r <= ptr_nxt;
         ptr_set_r <= ptr_set_nxt;
         read_r <= read_nxt;
         drv_r <= drv_nxt;
      end
   end
endmodule : dcm_i2c_slave

// ---- src/dcm_reg_map.sv ----
// Register map of the dual card multiplexer: identity, status, slot power control and input debounce.
`timescale 1ns/1ps
module dcm_reg_map #(
   parameter logic [6:0] DEV_ADDR = dcm_pkg::I2C_DEV_ADDR_DEF,
   parameter logic [3:0] MAKER_NIBBLE = dcm_pkg::MAKER_NIBBLE_DEF, // Arbitrary value.
   parameter logic [3:0] DEVICE_NIBBLE = dcm_pkg::DEVICE_NIBBLE_DEF, // Arbitrary value.
   parameter int TICK_CYCLES = dcm_pkg::DEB_TICK_CYC
) (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Two-wire register port.
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_drv_b_o,
   output logic sda_o,
   // Detection inputs.
   input wire logic card_switch_input_i,
   input wire logic battery_sense_input_i,
   // Slot supply controls, index 0 is slot 1.
   output logic [1:0] slot_supply_en_o,
   output logic [1:0] slot_supply_pulldown_o,
   output logic [1:0] slot_supply_vsel_o,
   output logic [3:0] slot_if_state_o,
   // Further control bytes and debounced input levels for the surrounding logic.
   output logic [7:0] timing_source_ctrl_o,
   output logic [7:0] detect_dir_ctrl_o,
   output logic [7:0] pin_pullup_ctrl_o,
   output logic card_switch_stable_o,
   output logic battery_removed_o
);
   import dcm_pkg::*;

   dcm_reg_if bus ();

   logic [7:0] slot_ctrl_r;
   logic [7:0] deb_count_r [2];
   logic [7:0] clk_ctrl_r;
   logic [7:0] dev_ctrl_r;
   logic [7:0] pullup_r;
   logic [7:0] test_r [TEST_REGS];
   logic [1:0] in_s1_r;
   logic [1:0] in_s2_r;
   logic [1:0] stable_r;
   logic [1:0] stable_d_r;
   logic [7:0] deb_cnt_r [2];
   logic [15:0] tick_cnt_r;
   logic tick_r;
   logic sw_flag_r;
   logic bat_flag_r;
   logic [1:0] slot_status [2];
   logic [7:0] status_byte;
   logic [7:0] test_byte;
   logic [2:0] test_idx;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Serial slave feeding the register strobes.
   dcm_i2c_slave #(
      .DEV_ADDR(DEV_ADDR)
   ) u_slave (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_drv_b_o(sda_drv_b_o),
      .bus(bus.master)
   );

   // The bus pin is only ever pulled low; release is done through the enable.
   assign sda_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Write decode.
   wire wr_slot = bus.wr_stb && (bus.addr == OFS_SLOT_CTRL);
   wire wr_bat_deb = bus.wr_stb && (bus.addr == OFS_BAT_DEB);
   wire wr_sw_deb = bus.wr_stb && (bus.addr == OFS_SW_DEB);
   wire wr_clk = bus.wr_stb && (bus.addr == OFS_CLK_CTRL);
   wire wr_dev = bus.wr_stb && (bus.addr == OFS_DEV_CTRL);
   wire wr_pullup = bus.wr_stb && (bus.addr == OFS_PULLUP);
   wire in_test = (bus.addr >= OFS_TEST_FIRST) && (bus.addr <= OFS_TEST_LAST);
   wire rd_status = bus.rd_stb && (bus.addr == OFS_STATUS);

   // Slot control byte; the reserved byte at 0Ch ignores writes.
   always_ff @(posedge clk_sys_i) begin
      slot_ctrl_r <= !rst_b_i ? RST_ZERO : (wr_slot ? bus.wdata : slot_ctrl_r);
   end

   // Debounce count bytes, index 0 for the card switch and 1 for battery sense.
   always_ff @(posedge clk_sys_i) begin
      deb_count_r[0] <= !rst_b_i ? RST_DEB_COUNT : (wr_sw_deb ? bus.wdata : deb_count_r[0]);
      deb_count_r[1] <= !rst_b_i ? RST_DEB_COUNT : (wr_bat_deb ? bus.wdata : deb_count_r[1]);
   end

   // Clock source, detection and pull-up control bytes.
   always_ff @(posedge clk_sys_i) begin
      clk_ctrl_r <= !rst_b_i ? RST_ZERO : (wr_clk ? bus.wdata : clk_ctrl_r);
      dev_ctrl_r <= !rst_b_i ? RST_ZERO : (wr_dev ? bus.wdata : dev_ctrl_r);
      pullup_r <= !rst_b_i ? RST_ZERO : (wr_pullup ? bus.wdata : pullup_r);
   end

   // Factory test bytes: plain storage, one per offset.
   assign test_idx = 3'(bus.addr - OFS_TEST_FIRST);
   generate
      for (genvar t = 0; t < TEST_REGS; t++) begin : g_test
         wire wr_this = bus.wr_stb && in_test && (test_idx == 3'(t));
         always_ff @(posedge clk_sys_i) begin
            test_r[t] <= !rst_b_i ? RST_ZERO : (wr_this ? bus.wdata : test_r[t]);
         end
      end
   endgenerate
   assign test_byte = (test_idx < 3'(TEST_REGS)) ? test_r[test_idx] : UNMAPPED_READ;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Debounce time base: one pulse every TICK_CYCLES clocks.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i || tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
         tick_cnt_r <= 16'h0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      tick_r <= rst_b_i && (tick_cnt_r == 16'(TICK_CYCLES - 1));
   end

   // Input synchronisers and filters: a new level is taken once it has held for the programmed tick count.
   generate
      for (genvar i = 0; i < 2; i++) begin : g_filter
         wire raw = (i == 0) ? card_switch_input_i : battery_sense_input_i;
         wire differs = in_s2_r[i] != stable_r[i];
         wire expired = deb_cnt_r[i] >= deb_count_r[i];

         always_ff @(posedge clk_sys_i) begin
            in_s1_r[i] <= rst_b_i ? raw : 1'b0;
            in_s2_r[i] <= rst_b_i ? in_s1_r[i] : 1'b0;
         end

         // Count ticks while the input disagrees; restart as soon as it agrees again.
         always_ff @(posedge clk_sys_i) begin
            if (!rst_b_i || !differs || expired) begin
               deb_cnt_r[i] <= 8'h00;
            end else if (tick_r) begin
               deb_cnt_r[i] <= deb_cnt_r[i] + 8'h01;
            end
         end

         always_ff @(posedge clk_sys_i) begin
            stable_r[i] <= !rst_b_i ? 1'b0 : ((differs && expired) ? in_s2_r[i] : stable_r[i]);
            stable_d_r[i] <= rst_b_i ? stable_r[i] : 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Events: any settled change of the card switch, and a settled rise of the battery-removed level.
   wire sw_event = stable_r[0] != stable_d_r[0];
   wire bat_event = stable_r[1] && !stable_d_r[1];

   // Sticky flags; an event in the cycle of the clearing read wins over the clear.
   always_ff @(posedge clk_sys_i) begin
      sw_flag_r <= rst_b_i && (sw_event || (sw_flag_r && !rd_status));
      bat_flag_r <= rst_b_i && (bat_event || (bat_flag_r && !rd_status));
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Slot status: the state field shows only while the regulator is on, otherwise powered down.
   generate
      for (genvar s = 0; s < 2; s++) begin : g_slot
         localparam int B = s * SC_NIBBLE;
         wire reg_on = slot_ctrl_r[B + SC_REG_EN];
         assign slot_status[s] = reg_on ? slot_ctrl_r[B + SC_STATE_LSB +: 2] : SLOT_POWERED_DOWN;
         assign slot_supply_en_o[s] = reg_on;
         assign slot_supply_pulldown_o[s] = !reg_on;
         assign slot_supply_vsel_o[s] = slot_ctrl_r[B + SC_VSEL];
         assign slot_if_state_o[2 * s +: 2] = slot_ctrl_r[B + SC_STATE_LSB +: 2];
      end
   endgenerate

   // Status byte assembly.
   assign status_byte[ST_SW_LEVEL] = in_s2_r[0];
   assign status_byte[ST_SW_FLAG] = sw_flag_r;
   assign status_byte[ST_BAT_GONE] = stable_r[1];
   assign status_byte[ST_BAT_FLAG] = bat_flag_r;
   assign status_byte[ST_SLOT1_LSB +: 2] = slot_status[0];
   assign status_byte[ST_SLOT2_LSB +: 2] = slot_status[1];

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Read selection; the reserved byte and unmapped offsets read as zero.
   wire [7:0] ident_byte = {MAKER_NIBBLE, DEVICE_NIBBLE};
   assign bus.rdata = (bus.addr == OFS_IDENT) ? ident_byte :
                      (bus.addr == OFS_DRV_VER) ? DRV_VERSION :
                      (bus.addr == OFS_STATUS) ? status_byte :
                      (bus.addr == OFS_SLOT_CTRL) ? slot_ctrl_r :
                      (bus.addr == OFS_BAT_DEB) ? deb_count_r[1] :
                      (bus.addr == OFS_SW_DEB) ? deb_count_r[0] :
                      (bus.addr == OFS_CLK_CTRL) ? clk_ctrl_r :
                      (bus.addr == OFS_DEV_CTRL) ? dev_ctrl_r :
                      (bus.addr == OFS_PULLUP) ? pullup_r :
                      in_test ? test_byte : UNMAPPED_READ;

   // Control bytes and debounced input levels exported to the surrounding logic.
   assign timing_source_ctrl_o = clk_ctrl_r;
   assign detect_dir_ctrl_o = dev_ctrl_r;
   assign pin_pullup_ctrl_o = pullup_r;
   assign card_switch_stable_o = stable_r[0];
   assign battery_removed_o = stable_r[1];
endmodule : dcm_reg_map

// ---- dv/dcm_host_model.sv ----
// Two-wire bus master model standing in for the baseband host.
`timescale 1ns/1ps
module dcm_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h35
) (
   // Clock.
   input wire logic clk_sys_i,
   // Bus pins.
   input wire logic sda_line_i,
   output logic scl_o,
   output logic sda_o,
   // Read byte report.
   output logic rd_valid_o,
   output logic [7:0] rd_data_o
);
   int bad_acks = 0;

   // The bus idles released, with no byte reported.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      rd_valid_o = 1'b0;
      rd_data_o = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Six clocks per phase keeps every phase above the four-clock minimum.
   task automatic half();
      repeat (6) @(negedge clk_sys_i);
   endtask : half

   // Start, also used as a repeated start; data moves one clock after the clock line falls.
   task automatic start();
      @(negedge clk_sys_i);
      sda_o = 1'b1;
      half();
      scl_o = 1'b1;
      half();
      sda_o = 1'b0;
      half();
      scl_o = 1'b0;
   endtask : start

   task automatic stop();
      @(negedge clk_sys_i);
      sda_o = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      sda_o = 1'b1;
      half();
   endtask : stop

   // One bit; the wire is sampled late in the high phase, long after the device has settled it.
   task automatic clk_bit(input logic b, output logic got);
      @(negedge clk_sys_i);
      sda_o = b;
      half();
      scl_o = 1'b1;
      half();
      got = sda_line_i;
      scl_o = 1'b0;
   endtask : clk_bit

   task automatic send(input logic [7:0] b, output logic ok);
      logic nc;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(b[i], nc);
      end
      clk_bit(1'b1, nc);
      ok = ~nc;
   endtask : send

   // Sends a byte that must be acknowledged and tallies any refusal.
   task automatic put(input logic [7:0] b);
      logic ok;
      send(b, ok);
      if (ok !== 1'b1) begin
         bad_acks++;
      end
   endtask : put

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      start();
      put({DEV_ADDR, 1'b0});
      put(a);
      put(d);
      stop();
   endtask : reg_write

   // Reads n bytes from a pointer; the last byte is refused to end the read.
   task automatic reg_read(input logic [7:0] a, input int n);
      logic [7:0] d;
      logic nc;
      start();
      put({DEV_ADDR, 1'b0});
      put(a);
      start();
      put({DEV_ADDR, 1'b1});
      for (int i = 0; i < n; i++) begin
         for (int j = 7; j >= 0; j--) begin
            clk_bit(1'b1, d[j]);
         end
         clk_bit(i == n - 1, nc);
         rd_data_o = d;
         rd_valid_o = 1'b1;
         @(negedge clk_sys_i);
         rd_valid_o = 1'b0;
      end
      stop();
   endtask : reg_read
endmodule : dcm_host_model

// ---- dv/dcm_reg_map_asserts.sv ----
// Concurrent checks on the ports of the card multiplexer register map.
`timescale 1ns/1ps
module dcm_reg_map_asserts (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Two-wire pins.
   input wire logic scl_i,
   input wire logic sda_drv_b_o,
   input wire logic sda_o,
   // Detection pins.
   input wire logic card_switch_input_i,
   input wire logic battery_sense_input_i,
   input wire logic card_switch_stable_o,
   input wire logic battery_removed_o,
   // Slot pins.
   input wire logic [1:0] slot_supply_en_o,
   input wire logic [1:0] slot_supply_pulldown_o,
   input wire logic [1:0] slot_supply_vsel_o,
   input wire logic [3:0] slot_if_state_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   // A long high phase of the bus clock, in which no register write can land.
   sequence scl_quiet;
      scl_i [*8];
   endsequence
   sequence in_reset;
      !rst_b_i;
   endsequence

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Slot, bus and debounce relations.
   chk_pulldown_inverse: assert property (slot_supply_pulldown_o == ~slot_supply_en_o)
      else $error("slot pull-down does not mirror regulator enable");
   chk_slot_reset: assert property (disable iff (1'b0) in_reset |=>
      slot_supply_en_o == 2'h0 && slot_supply_vsel_o == 2'h0 && slot_if_state_o == 4'h0)
      else $error("slot controls not cleared by reset");
   chk_sda_reset: assert property (disable iff (1'b0) in_reset |=> sda_drv_b_o)
      else $error("data line held during reset");
   chk_sda_zero: assert property (sda_o == 1'b0)
      else $error("data line drive value not low");
   chk_sda_on_low: assert property ($changed(sda_drv_b_o) |-> !scl_i && !$past(scl_i))
      else $error("data line drive changed while bus clock high");
   chk_switch_follow: assert property ($changed(card_switch_stable_o) |->
      card_switch_stable_o == $past(card_switch_input_i, 3))
      else $error("switch level accepted without holding");
   chk_battery_follow: assert property ($changed(battery_removed_o) |->
      battery_removed_o == $past(battery_sense_input_i, 3))
      else $error("battery level accepted without holding");
   chk_write_quiet: assert property (scl_quiet |-> $stable(slot_supply_en_o) &&
      $stable(slot_if_state_o) && $stable(slot_supply_vsel_o))
      else $error("slot controls changed outside a bus write");
endmodule : dcm_reg_map_asserts

bind dcm_reg_map dcm_reg_map_asserts u_chk (
   .clk_sys_i,
   .rst_b_i,
   .scl_i,
   .sda_drv_b_o,
   .sda_o,
   .card_switch_input_i,
   .battery_sense_input_i,
   .card_switch_stable_o,
   .battery_removed_o,
   .slot_supply_en_o,
   .slot_supply_pulldown_o,
   .slot_supply_vsel_o,
   .slot_if_state_o
);

// ---- dv/tb_dcm_reg_map.sv ----
// Self-checking bench of the card multiplexer register map driven by a bus master model.
`timescale 1ns/1ps
module tb_dcm_reg_map;
   import dcm_pkg::*;
   localparam int TICKS = 4;
   localparam int DEB = 2;
   logic clk_sys_i, rst_b_i, scl, sda_m, sda_line, sda_drv_b, sda_dut, rd_valid, sw_in, bat_in, sw_st, bat_rm, ack;
   logic [7:0] rd_data, tsc, ddc, ppc, v;
   logic [1:0] en, pd, vsel;
   logic [3:0] state;
   logic [15:0] lfsr;
   logic [7:0] exp_q[$];
   logic [7:0] wv[5];
   logic [7:0] rst_ofs[10] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h15};
   logic [7:0] rst_val[10] = '{{MAKER_NIBBLE_DEF, DEVICE_NIBBLE_DEF}, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00,
      8'h00, 8'h00, 8'h00};
   logic [7:0] rw_ofs[5] = '{8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h15};
   int miscompares = 0;
   int cmp_count = 0;

   // Open-drain data wire with pull-up.
   assign sda_line = sda_m & (sda_drv_b | sda_dut);

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   dcm_reg_map #(.TICK_CYCLES(TICKS)) u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .scl_i(scl),
      .sda_i(sda_line), .sda_drv_b_o(sda_drv_b), .sda_o(sda_dut), .card_switch_input_i(sw_in),
      .battery_sense_input_i(bat_in), .slot_supply_en_o(en), .slot_supply_pulldown_o(pd),
      .slot_supply_vsel_o(vsel), .slot_if_state_o(state), .timing_source_ctrl_o(tsc),
      .detect_dir_ctrl_o(ddc), .pin_pullup_ctrl_o(ppc), .card_switch_stable_o(sw_st),
      .battery_removed_o(bat_rm));

   dcm_host_model #(.DEV_ADDR(I2C_DEV_ADDR_DEF)) u_host (.clk_sys_i(clk_sys_i), .sda_line_i(sda_line),
      .scl_o(scl), .sda_o(sda_m), .rd_valid_o(rd_valid), .rd_data_o(rd_data));

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // Status byte: slot field reads zero while that slot's regulator is off.
   function automatic logic [7:0] st(input logic [7:0] c, input logic [3:0] ev);
      return {c[4] ? c[7:6] : 2'b00, c[0] ? c[3:2] : 2'b00, ev};
   endfunction : st

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic final_report();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   task automatic rd1(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.reg_read(a, 1);
   endtask : rd1

   task automatic do_reset();
      @(negedge clk_sys_i);
      rst_b_i = 1'b0;
      repeat (12) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
   endtask : do_reset

   // Bounded wait for a debounced level, which must not come before the count has run.
   task automatic wait_hi(ref logic s, input int cnt, input string what);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 200) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk({7'h00, s}, 8'h01, what);
      chk({7'h00, n >= (cnt - 1) * TICKS}, 8'h01, "debounce too short");
      if (n == 200) begin
         final_report();
      end
   endtask : wait_hi

   // Read results are compared in arrival order against the notes of the driver.
   always @(posedge clk_sys_i) begin
      if (rd_valid === 1'b1) begin
         chk(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX, "read data");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b_i = 1'b0;
      sw_in = 1'b0;
      bat_in = 1'b0;
      lfsr = 16'h6D5F;
      do_reset();
      chk({en, vsel, state}, 8'h00, "slot pins at reset");
      chk({6'h00, pd}, 8'h03, "pull-downs at reset");
      foreach (rst_ofs[i]) begin
         rd1(rst_ofs[i], rst_val[i]);
      end
      // Read-only and reserved places ignore writes; the pointer runs on into an unmapped byte.
      foreach (rst_ofs[i]) begin
         if (i < 3 || i == 6) begin
            u_host.reg_write(rst_ofs[i], 8'hFF);
         end
      end
      exp_q.push_back(rst_val[0]);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
      u_host.reg_read(8'h00, 3);
      rd1(8'h04, 8'h00);
      rd1(8'h0C, 8'h00);
      foreach (rw_ofs[i]) begin
         lfsr = lfsr_next(lfsr);
         wv[i] = lfsr[7:0];
         u_host.reg_write(rw_ofs[i], wv[i]);
         rd1(rw_ofs[i], wv[i]);
      end
      chk(tsc, wv[2], "clock control copy");
      chk(ddc, wv[3], "device control copy");
      chk(ppc, wv[4], "pull-up control copy");
      // Every state code with the regulator on and off, on both slots.
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         v = {~i[1:0], lfsr[5], ~i[2], i[1:0], lfsr[1], i[2]};
         u_host.reg_write(8'h08, v);
         chk({en, vsel, state}, {v[4], v[0], v[5], v[1], v[7:6], v[3:2]}, "slot pins");
         chk({6'h00, pd}, {6'h00, ~v[4], ~v[0]}, "pull-downs");
         rd1(8'h04, st(v, 4'h0));
      end
      do_reset();
      chk({en, vsel, state}, 8'h00, "slot pins after reset");
      rd1(8'h08, 8'h00);
      v = 8'hDD;
      u_host.reg_write(8'h08, v);
      u_host.reg_write(8'h0A, 8'(4 * DEB));
      u_host.reg_write(8'h0B, 8'(DEB));
      // A glitch shorter than the count is filtered out.
      sw_in = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      sw_in = 1'b0;
      repeat (20) @(negedge clk_sys_i);
      chk({7'h00, sw_st}, 8'h00, "glitch passed");
      sw_in = 1'b1;
      wait_hi(sw_st, DEB, "switch level");
      rd1(8'h04, st(v, 4'b0011));
      rd1(8'h04, st(v, 4'b0001));
      bat_in = 1'b1;
      wait_hi(bat_rm, 4 * DEB, "battery level");
      rd1(8'h04, st(v, 4'b1101));
      rd1(8'h04, st(v, 4'b0101));
      // A foreign address is not acknowledged.
      u_host.start();
      u_host.send({I2C_DEV_ADDR_DEF ^ 7'h01, 1'b0}, ack);
      u_host.stop();
      chk({7'h00, ack}, 8'h00, "foreign address acked");
      repeat (5) @(negedge clk_sys_i);
      chk({7'h00, u_host.bad_acks == 0}, 8'h01, "missing ack");
      chk({7'h00, exp_q.size() == 0}, 8'h01, "reads missing");
      final_report();
   end
endmodule : tb_dcm_reg_map
